// ===== design/msa_pkg.sv
// Package with offsets, preset values and encodings of the converter control block
package msa_pkg;
	// Register byte offsets on the Avalon slave
	localparam logic [5:0] OFS_CTRL   = 6'h00;
	localparam logic [5:0] OFS_RES    = 6'h04;
	localparam logic [5:0] OFS_INTEG  = 6'h08;
	localparam logic [5:0] OFS_AZERO  = 6'h0C;
	localparam logic [5:0] OFS_DIGITS = 6'h10;
	localparam logic [5:0] OFS_FILTER = 6'h14;
	localparam logic [5:0] OFS_SDELAY = 6'h18;
	localparam logic [5:0] OFS_RUN    = 6'h1C;
	localparam logic [5:0] OFS_STATUS = 6'h20;

	// Clock rate
	localparam int CLK_PERIOD_NS = 50;

	// Integration length counts in steps of 0.002 line cycles
	localparam logic [12:0] INTEG_STEPS_PER_CYCLE = 13'h01F4; // 1.0 cycle
	localparam logic [12:0] INTEG_MIN             = 13'h0001; // 0.002
	localparam logic [12:0] INTEG_6P5             = 13'h01F4; // 1.0
	localparam logic [12:0] INTEG_5P5             = 13'h0032; // 0.1
	localparam logic [12:0] INTEG_4P5             = 13'h0001; // 0.002
	localparam logic [12:0] INTEG_MAX_60          = 13'h1D4C; // 15
	localparam logic [12:0] INTEG_MAX_50          = 13'h1770; // 12

	// Resolution codes, also the displayed digit counts
	localparam logic [2:0] RES_4P5 = 3'h4;
	localparam logic [2:0] RES_5P5 = 3'h5;
	localparam logic [2:0] RES_6P5 = 3'h6;

	// Filter defaults loaded by every preset; window in 0.01 percent steps
	localparam logic [6:0]  FILT_COUNT  = 7'h0A;
	localparam logic [15:0] FILT_WINDOW = 16'h0001;

	// Source delay in microseconds
	localparam logic [15:0] SDELAY_ON_US  = 16'h03E8; // 1 ms
	localparam logic [15:0] SDELAY_OFF_US = 16'h0000;

	// Values after reset
	localparam logic [1:0] RST_FUNC = 2'h0;
	localparam logic [1:0] RST_MODE = 2'h0;

	// Measurement functions and operating modes
	typedef enum logic [1:0] {FN_CURR, FN_VOLT, FN_CONC} msa_fn_e;
	typedef enum logic [1:0] {MODE_PS, MODE_BATT_TEST, MODE_BATT_SIM} msa_mode_e;
	// Conversion kinds driven to the converter
	typedef enum logic [1:0] {CK_USER, CK_ZERO, CK_GAIN} msa_kind_e;
endpackage : msa_pkg

// ===== design/msa_ctrl.sv
// Measurement speed and accuracy control with Avalon-MM registers and conversion sequencer
// Notes on behaviour
// - Resolution presets are accepted only in the power supply mode.
// - Battery modes force the 6.5 digit preset and ignore resolution writes.
// - Presets load integration 1.0/0.1/0.002 cycles, autozero on/off/off, matching digits.
// - Every preset sets filter count 10, window 0.01 percent; filter on only at 6.5.
// - 5.5 and 6.5 enable 1 ms source delay; 4.5 disables it with zero.
// - Resolution code 4, 5, 6 selects 4.5, 5.5, 6.5 digits.
// - Resolution is kept per function; a change hits only the selected function.
// - Integration time is cycle count times line period, 16.67 ms or 20 ms.
// - Integration count ranges 0.002 to 15 at 60 Hz, 12 at 50 Hz.
// - Each function keeps its own integration count, settable on its own.
// - Autozero in power supply mode adds zero and gain reference conversions.
// - Battery modes disable reference conversions whatever autozero holds.
// - With autozero, conversions per reading are 5 concurrent, 4 current, 3 voltage.
// - Without autozero, conversions are 2 concurrent, 1 current, 1 voltage.
// - Run length is conversions times readings times integration count times period.
// - Autozero off skips all reference conversions.
// - Autozero setting is stored per function and restored on reselect.
// - Writing displayed digits alone leaves integration and autozero untouched.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module msa_ctrl #(
	parameter int LINE_PERIOD_60_NS = 16_670_000,
	parameter int LINE_PERIOD_50_NS = 20_000_000
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Converter side
	output logic             conv_active,
	output logic      [1:0]  conv_kind,
	output logic             run_busy
);
	// Line period as clock counts
	localparam int LINE_60_CYC = LINE_PERIOD_60_NS / msa_pkg::CLK_PERIOD_NS;
	localparam int LINE_50_CYC = LINE_PERIOD_50_NS / msa_pkg::CLK_PERIOD_NS;

	// Conversions per reading for a function and autozero state
	function automatic logic [2:0] conv_per_reading(input logic [1:0] fn, input logic az);
		logic [2:0] n;
		if (fn == msa_pkg::FN_CONC)
			n = az ? 3'h5 : 3'h2;
		else if (fn == msa_pkg::FN_CURR)
			n = az ? 3'h4 : 3'h1;
		else
			n = az ? 3'h3 : 3'h1;
		return n;
	endfunction : conv_per_reading

	// Byte-lane merge of a write into the current word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				m[i*8 +: 8] = nw[i*8 +: 8];
		end
		return m;
	endfunction : merge

	// Configuration state
	logic [1:0]  func_sel,  next_func_sel;
	logic [1:0]  op_mode,   next_op_mode;
	logic        line_50,   next_line_50;
	logic [12:0] integ     [3];
	logic [12:0] next_integ[3];
	logic        az        [3];
	logic        next_az   [3];
	logic [2:0]  digits    [3];
	logic [2:0]  next_digits[3];
	logic        filt_on   [3];
	logic        next_filt_on[3];
	logic        sdly_on   [3];
	logic        next_sdly_on[3];
	logic        ack,       next_ack;
	logic [31:0] rdata,     next_rdata;

	// Sequencer state
	typedef enum logic {SQ_IDLE, SQ_CONV} msa_seq_e;
	msa_seq_e    seq,       next_seq;
	logic [15:0] rd_left,   next_rd_left;
	logic [2:0]  conv_idx,  next_conv_idx;
	logic [2:0]  conv_tot,  next_conv_tot;
	logic [2:0]  user_tot,  next_user_tot;
	logic [22:0] cyc_left,  next_cyc_left;
	logic [22:0] run_len,   next_run_len;
	logic [1:0]  next_conv_kind;

	// Effective settings of the selected function
	logic        batt;
	logic [12:0] eff_integ;
	logic        eff_az;
	logic [2:0]  eff_digits;
	logic [12:0] integ_max;
	logic [22:0] int_cyc;
	logic [31:0] word;
	logic        wr_take;
	logic        rd_take;
	logic [31:0] mw;

	// Battery modes run at the best preset with no references
	always_comb begin
		batt       = (op_mode != msa_pkg::MODE_PS);
		eff_integ  = batt ? msa_pkg::INTEG_6P5 : integ[func_sel];
		eff_az     = batt ? 1'b0 : az[func_sel];
		eff_digits = batt ? msa_pkg::RES_6P5 : digits[func_sel];
		integ_max  = line_50 ? msa_pkg::INTEG_MAX_50 : msa_pkg::INTEG_MAX_60;
		int_cyc    = 23'((33'(eff_integ) * 33'(line_50 ? LINE_50_CYC : LINE_60_CYC))
			/ 33'(msa_pkg::INTEG_STEPS_PER_CYCLE));
	end

	// Read mux of the register view
	always_comb begin
		word = 32'h0000_0000;
		unique case (avs_address)
			msa_pkg::OFS_CTRL:   word = {27'h0, line_50, op_mode, func_sel};
			msa_pkg::OFS_RES:    word = {29'h0, eff_digits};
			msa_pkg::OFS_INTEG:  word = {19'h0, eff_integ};
			msa_pkg::OFS_AZERO:  word = {31'h0, eff_az};
			msa_pkg::OFS_DIGITS: word = {29'h0, eff_digits};
			msa_pkg::OFS_FILTER: word = {msa_pkg::FILT_WINDOW, 7'h0, filt_on[func_sel] & ~batt, 1'b0,
				msa_pkg::FILT_COUNT};
			msa_pkg::OFS_SDELAY: word = {sdly_on[func_sel] ? msa_pkg::SDELAY_ON_US : msa_pkg::SDELAY_OFF_US,
				15'h0, sdly_on[func_sel]};
			msa_pkg::OFS_RUN:    word = {rd_left, 15'h0, run_busy};
			msa_pkg::OFS_STATUS: word = {9'h0, run_len[22:0]};
			default:             word = 32'h0000_0000; // Unmapped reads return zero
		endcase
	end

	// Bus handshake: one wait cycle, taken at the edge where waitrequest is low
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign wr_take         = avs_write & ack;
	assign rd_take         = avs_read & ack;
	assign avs_readdata    = rdata;
	assign mw              = merge(word, avs_writedata, avs_byteenable);

	// Next configuration and bus values
	always_comb begin
		next_func_sel = func_sel;
		next_op_mode  = op_mode;
		next_line_50  = line_50;
		next_integ    = integ;
		next_az       = az;
		next_digits   = digits;
		next_filt_on  = filt_on;
		next_sdly_on  = sdly_on;
		next_ack      = (avs_read | avs_write) & ~ack;
		next_rdata    = (avs_read & ~ack) ? word : rdata;
		if (wr_take) begin
			unique case (avs_address)
				msa_pkg::OFS_CTRL: begin
					if (mw[1:0] <= 2'h2)
						next_func_sel = mw[1:0];
					if (mw[3:2] <= 2'h2)
						next_op_mode = mw[3:2];
					next_line_50 = mw[4];
				end
				msa_pkg::OFS_RES: begin
					// Only the selected function is loaded
					if (!batt) begin
						unique case (mw[2:0])
							msa_pkg::RES_6P5: begin
								next_integ[func_sel]   = msa_pkg::INTEG_6P5;
								next_az[func_sel]      = 1'b1;
								next_digits[func_sel]  = msa_pkg::RES_6P5;
								next_filt_on[func_sel] = 1'b1;
								next_sdly_on[func_sel] = 1'b1;
							end
							msa_pkg::RES_5P5: begin
								next_integ[func_sel]   = msa_pkg::INTEG_5P5;
								next_az[func_sel]      = 1'b0;
								next_digits[func_sel]  = msa_pkg::RES_5P5;
								next_filt_on[func_sel] = 1'b0;
								next_sdly_on[func_sel] = 1'b1;
							end
							msa_pkg::RES_4P5: begin
								next_integ[func_sel]   = msa_pkg::INTEG_4P5;
								next_az[func_sel]      = 1'b0;
								next_digits[func_sel]  = msa_pkg::RES_4P5;
								next_filt_on[func_sel] = 1'b0;
								next_sdly_on[func_sel] = 1'b0;
							end
							default: ; // Other codes are ignored
						endcase
					end
				end
				msa_pkg::OFS_INTEG: begin
					// Out of range counts are dropped, not clamped
					if (mw[12:0] >= msa_pkg::INTEG_MIN && mw[12:0] <= integ_max && mw[31:13] == 19'h0)
						next_integ[func_sel] = mw[12:0];
				end
				msa_pkg::OFS_AZERO: next_az[func_sel] = mw[0];
				msa_pkg::OFS_DIGITS: begin
					if (mw[2:0] >= msa_pkg::RES_4P5 && mw[2:0] <= msa_pkg::RES_6P5 && !batt)
						next_digits[func_sel] = mw[2:0];
				end
				default: ;
			endcase
		end
	end

	// Next sequencer values; each conversion lasts int_cyc clocks
	always_comb begin
		next_seq      = seq;
		next_rd_left  = rd_left;
		next_conv_idx = conv_idx;
		next_conv_tot = conv_tot;
		next_user_tot = user_tot;
		next_cyc_left = cyc_left;
		next_run_len  = run_len;
		unique case (seq)
			SQ_IDLE: begin
				if (wr_take && avs_address == msa_pkg::OFS_RUN && mw[15:0] != 16'h0) begin
					next_seq      = SQ_CONV;
					next_rd_left  = mw[15:0];
					next_conv_idx = 3'h0;
					next_conv_tot = conv_per_reading(func_sel, eff_az);
					next_user_tot = conv_per_reading(func_sel, 1'b0);
					next_cyc_left = int_cyc;
					next_run_len  = 23'h0;
				end
			end
			SQ_CONV: begin
				next_run_len = run_len + 23'h1;
				if (cyc_left > 23'h1) begin
					next_cyc_left = cyc_left - 23'h1;
				end else begin
					next_cyc_left = int_cyc;
					if (conv_idx + 3'h1 < conv_tot) begin
						next_conv_idx = conv_idx + 3'h1;
					end else begin
						next_conv_idx = 3'h0;
						next_rd_left  = rd_left - 16'h1;
						if (rd_left == 16'h1)
							next_seq = SQ_IDLE;
					end
				end
			end
		endcase
		// User conversions first, then zero and gain references; registered so the converter sees no glitch
		if (next_seq != SQ_CONV || next_conv_idx < next_user_tot)
			next_conv_kind = msa_pkg::CK_USER;
		else if (next_conv_idx[0] == next_user_tot[0])
			next_conv_kind = msa_pkg::CK_ZERO;
		else
			next_conv_kind = msa_pkg::CK_GAIN;
	end

	// Run flag seen by the converter and by software
	assign conv_active = (seq == SQ_CONV);
	assign run_busy    = (seq == SQ_CONV);

	// Registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			func_sel <= msa_pkg::RST_FUNC;
			op_mode  <= msa_pkg::RST_MODE;
			line_50  <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				integ[i]   <= msa_pkg::INTEG_6P5;
				az[i]      <= 1'b1;
				digits[i]  <= msa_pkg::RES_6P5;
				filt_on[i] <= 1'b1;
				sdly_on[i] <= 1'b1;
			end
			ack      <= 1'b0;
			rdata    <= 32'h0000_0000;
			seq      <= SQ_IDLE;
			rd_left  <= 16'h0000;
			conv_idx <= 3'h0;
			conv_tot <= 3'h0;
			user_tot <= 3'h0;
			cyc_left <= 23'h00_0000;
			run_len  <= 23'h00_0000;
			conv_kind <= msa_pkg::CK_USER;
		end else begin
			func_sel <= next_func_sel;
			op_mode  <= next_op_mode;
			line_50  <= next_line_50;
			integ    <= next_integ;
			az       <= next_az;
			digits   <= next_digits;
			filt_on  <= next_filt_on;
			sdly_on  <= next_sdly_on;
			ack      <= next_ack;
			rdata    <= next_rdata;
			seq      <= next_seq;
			rd_left  <= next_rd_left;
			conv_idx <= next_conv_idx;
			conv_tot <= next_conv_tot;
			user_tot <= next_user_tot;
			cyc_left <= next_cyc_left;
			run_len  <= next_run_len;
			conv_kind <= next_conv_kind;
		end
	end

	// Checks on preset loading, mode forcing and sequencing
	logic res_wr;
	assign res_wr = wr_take && avs_address == msa_pkg::OFS_RES;

	a_res_mode_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		res_wr && batt |=> $stable(digits[func_sel]) && $stable(integ[func_sel]))
		else $error("Resolution applied outside power supply mode");
	a_batt_forced: assert property (@(posedge ref_clk) disable iff (sys_rst)
		batt |-> !eff_az && eff_digits == msa_pkg::RES_6P5 && eff_integ == msa_pkg::INTEG_6P5)
		else $error("Battery mode not forced to best preset");
	a_preset_fast: assert property (@(posedge ref_clk) disable iff (sys_rst)
		res_wr && !batt && mw[2:0] == msa_pkg::RES_4P5 ##1 $stable(func_sel) |->
		integ[func_sel] == msa_pkg::INTEG_4P5 && !az[func_sel] && !filt_on[func_sel] && !sdly_on[func_sel])
		else $error("Fast preset values wrong");
	a_preset_best: assert property (@(posedge ref_clk) disable iff (sys_rst)
		res_wr && !batt && mw[2:0] == msa_pkg::RES_6P5 ##1 $stable(func_sel) |->
		integ[func_sel] == msa_pkg::INTEG_6P5 && az[func_sel] && filt_on[func_sel] && digits[func_sel] == 3'h6)
		else $error("Best preset values wrong");
	a_integ_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_take && avs_address == msa_pkg::OFS_INTEG && mw[12:0] > integ_max |=> $stable(integ[func_sel]))
		else $error("Out of range integration count accepted");
	a_digits_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_take && avs_address == msa_pkg::OFS_DIGITS |=> $stable(integ[func_sel]) && $stable(az[func_sel]))
		else $error("Digit write disturbed accuracy settings");
	a_conv_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
		seq == SQ_IDLE ##1 seq == SQ_CONV && $past(eff_az) && $past(func_sel) == msa_pkg::FN_CONC |->
		conv_tot == 3'h5)
		else $error("Concurrent autozero reading not five conversions");
	a_ref_skip: assert property (@(posedge ref_clk) disable iff (sys_rst)
		conv_active && conv_tot == user_tot |-> conv_kind == msa_pkg::CK_USER)
		else $error("Reference conversion without autozero");
endmodule : msa_ctrl

// ===== tb/msa_conv_model.sv
// Behavioural converter model that times each run and its reference conversions
`timescale 1ns/1ns
module msa_conv_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Conversion requests from the controller
	input  wire logic        conv_active,
	input  wire logic [1:0]  conv_kind,
	// Run summary, one cycle pulse when a run ends
	output logic             run_done,
	output logic      [22:0] all_cycles,
	output logic      [22:0] ref_cycles
);
	logic [22:0] tot;
	logic [22:0] refs;
	logic        was_on;

	// Count converting cycles; any kind other than user is a reference conversion
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tot        <= 23'h00_0000;
			refs       <= 23'h00_0000;
			was_on     <= 1'b0;
			run_done   <= 1'b0;
			all_cycles <= 23'h00_0000;
			ref_cycles <= 23'h00_0000;
		end else begin
			was_on   <= conv_active;
			run_done <= was_on & ~conv_active;
			if (conv_active) begin
				tot  <= tot + 23'h00_0001;
				refs <= refs + ((conv_kind != 2'h0) ? 23'h00_0001 : 23'h00_0000);
			end else if (was_on) begin
				// Totals are frozen at the falling edge of the run, so a slow reader still sees them
				all_cycles <= tot;
				ref_cycles <= refs;
				tot        <= 23'h00_0000;
				refs       <= 23'h00_0000;
			end
		end
	end
endmodule : msa_conv_model

// ===== tb/msa_ctrl_tb_top.sv
// Self-checking bench for the measurement speed and accuracy control block
`timescale 1ns/1ns
module msa_ctrl_tb_top;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        conv_active;
	logic [1:0]  conv_kind;
	logic        run_busy;
	logic        run_done;
	logic [22:0] all_cycles;
	logic [22:0] ref_cycles;
	logic [31:0] rd_q[$];
	logic [45:0] run_q[$];
	int          bad_count = 0;
	int          checks = 0;
	int          n;

	// Short line periods: 1000 cycles at 60 Hz, 1200 at 50 Hz
	msa_ctrl #(.LINE_PERIOD_60_NS(50_000), .LINE_PERIOD_50_NS(60_000)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.conv_active(conv_active), .conv_kind(conv_kind), .run_busy(run_busy));
	msa_conv_model CONV (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_active(conv_active), .conv_kind(conv_kind),
		.run_done(run_done), .all_cycles(all_cycles), .ref_cycles(ref_cycles));

	always #25 ref_clk = ~ref_clk;

	task automatic final_report();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value readdata expected %h seen %h", e, g);
		end
	endtask : chk_reg

	task automatic chk_run(input logic [45:0] e, input logic [45:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value run cycles expected %h seen %h", e, g);
		end
	endtask : chk_run

	// One Avalon access; the request stands until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= ~w;
		avs_writedata <= d;
		n = 0;
		// Waitrequest is seen as the slave saw it at this edge, before any update of the edge
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			bad_count++;
			final_report();
		end
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Readback of every field a preset loads, for the selected function
	task automatic chk_preset(input int c);
		logic        hi;
		logic        on;
		logic [12:0] ig;
		hi = (c == 6);
		on = (c != 4);
		ig = hi ? msa_pkg::INTEG_6P5 : (on ? msa_pkg::INTEG_5P5 : msa_pkg::INTEG_4P5);
		rd(msa_pkg::OFS_RES, 32'(c));
		rd(msa_pkg::OFS_INTEG, {19'h0_0000, ig});
		rd(msa_pkg::OFS_AZERO, {31'h0000_0000, hi});
		rd(msa_pkg::OFS_DIGITS, 32'(c));
		rd(msa_pkg::OFS_FILTER, {msa_pkg::FILT_WINDOW, 7'h00, hi, 1'b0, msa_pkg::FILT_COUNT});
		rd(msa_pkg::OFS_SDELAY, {on ? msa_pkg::SDELAY_ON_US : msa_pkg::SDELAY_OFF_US, 15'h0000, on});
	endtask : chk_preset

	// Start a run and wait for it to end; the partner reports cycle totals
	task automatic go(input logic [15:0] rds, input int tot, input int refc);
		run_q.push_back({tot[22:0], refc[22:0]});
		wr(msa_pkg::OFS_RUN, {16'h0000, rds});
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (run_busy !== 1'b0 && n < 40000);
		if (n >= 40000) begin
			bad_count++;
			final_report();
		end
		rd(msa_pkg::OFS_STATUS, {9'h000, tot[22:0]});
	endtask : go

	// Result watchers take the oldest note when a result appears; read data is taken at the accepting edge
	always @(posedge ref_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk_reg(rd_q.pop_front(), avs_readdata);
		if (run_done === 1'b1) chk_run(run_q.pop_front(), {all_cycles, ref_cycles});
	end

	// Hang guard
	initial begin
		#5_000_000;
		bad_count++;
		final_report();
	end

	// Main sequence
	initial begin
		int rds;
		int us;
		int cv;
		n = $urandom(47);
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk_preset(6);
		rd(6'h24, 32'h0000_0000);
		for (int c = 4; c <= 6; c++) begin
			wr(msa_pkg::OFS_RES, 32'(c));
			chk_preset(c);
		end
		wr(msa_pkg::OFS_RES, 32'h0000_0003);
		rd(msa_pkg::OFS_RES, 32'h0000_0006);
		// Per-function storage: voltage to 4.5, current keeps 6.5
		wr(msa_pkg::OFS_CTRL, 32'h0000_0001);
		wr(msa_pkg::OFS_RES, 32'h0000_0004);
		wr(msa_pkg::OFS_CTRL, 32'h0000_0000);
		chk_preset(6);
		wr(msa_pkg::OFS_CTRL, 32'h0000_0001);
		chk_preset(4);
		wr(msa_pkg::OFS_DIGITS, 32'h0000_0005);
		rd(msa_pkg::OFS_DIGITS, 32'h0000_0005);
		rd(msa_pkg::OFS_INTEG, 32'h0000_0001);
		rd(msa_pkg::OFS_AZERO, 32'h0000_0000);
		// Integration count limits at 60 Hz then 50 Hz
		wr(msa_pkg::OFS_INTEG, 32'h0000_1D4C);
		wr(msa_pkg::OFS_INTEG, 32'h0000_1D4D);
		wr(msa_pkg::OFS_INTEG, 32'h0000_0000);
		rd(msa_pkg::OFS_INTEG, 32'h0000_1D4C);
		wr(msa_pkg::OFS_CTRL, 32'h0000_0011);
		wr(msa_pkg::OFS_INTEG, 32'h0000_1770);
		wr(msa_pkg::OFS_INTEG, 32'h0000_1771);
		rd(msa_pkg::OFS_INTEG, 32'h0000_1770);
		wr(msa_pkg::OFS_INTEG, 32'h0000_0005);
		go(16'h0001, 12, 0);
		// Conversions per reading for each function, autozero on and off
		for (int f = 0; f < 3; f++) begin
			for (int a = 0; a < 2; a++) begin
				rds = $urandom_range(3, 1);
				us = (f == 2) ? 2 : 1;
				cv = (a == 0) ? us : ((f == 0) ? 4 : ((f == 1) ? 3 : 5));
				wr(msa_pkg::OFS_CTRL, 32'(f));
				wr(msa_pkg::OFS_INTEG, 32'h0000_0005);
				wr(msa_pkg::OFS_AZERO, 32'(a));
				go(16'(rds), cv * rds * 10, (cv - us) * rds * 10);
			end
		end
		// Battery modes override resolution and autozero
		wr(msa_pkg::OFS_CTRL, 32'h0000_0000);
		wr(msa_pkg::OFS_RES, 32'h0000_0005);
		wr(msa_pkg::OFS_AZERO, 32'h0000_0001);
		wr(msa_pkg::OFS_CTRL, 32'h0000_0004);
		wr(msa_pkg::OFS_RES, 32'h0000_0004);
		rd(msa_pkg::OFS_RES, 32'h0000_0006);
		rd(msa_pkg::OFS_INTEG, 32'h0000_01F4);
		rd(msa_pkg::OFS_AZERO, 32'h0000_0000);
		go(16'h0001, 1000, 0);
		wr(msa_pkg::OFS_CTRL, 32'h0000_0008);
		rd(msa_pkg::OFS_AZERO, 32'h0000_0000);
		wr(msa_pkg::OFS_CTRL, 32'h0000_0000);
		rd(msa_pkg::OFS_RES, 32'h0000_0005);
		repeat (4) @(posedge ref_clk);
		if (rd_q.size() + run_q.size() != 0) bad_count++;
		final_report();
	end
endmodule : msa_ctrl_tb_top
